/* File: bench/burst2_sram_port_properties.sv */
// assertions on the burst-of-two sram port pins
// one core clock; bound onto every port instance
`timescale 1ns/1ps
module burst2_sram_port_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link pins
  input wire logic k_true,
  input wire logic read_sel_n,
  input wire logic dll_disable_n,
  input wire logic termination_select,
  input wire logic termination_select_float,
  // outputs
  input wire logic term_clk_on,
  input wire logic term_data_on,
  input wire logic term_strong,
  input wire logic data_out_oe_n,
  input wire logic device_ready,
  input wire logic dll_locked
);
  logic [2:0] ks;
  logic [2:0] rhist;
  logic [3:0] kidle;
  int kcnt;
  wire logic ktr = ks[1] & ~ks[2];
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // own copy of the k_true edge detect
  always_ff @(posedge clk)
  begin
    ks <= {ks[1:0], k_true};
    if (ktr)
      rhist <= {rhist[1:0], ~read_sel_n};
  end
  always_ff @(posedge clk)
    if (!rstn || ks[1] != ks[2])
      kidle <= 4'h0;
    else if (kidle != 4'hF)
      kidle <= kidle + 4'h1;
  always_ff @(posedge clk)
    if (!rstn || kidle > 4'h3 || $rose(dll_disable_n))
      kcnt <= 0;
    else if (ktr)
      kcnt <= kcnt + 1;
  property p_term_strong;
    (!termination_select && !termination_select_float) [*6] |->
      term_strong && term_clk_on && term_data_on;
  endproperty
  a_term_strong: assert property (p_term_strong) else $error("strong term");
  property p_term_weak;
    (termination_select || termination_select_float) [*6] |-> !term_strong;
  endproperty
  a_term_weak: assert property (p_term_weak) else $error("weak term");
  property p_lock_wait;
    $rose(device_ready) |-> kcnt >= 2040;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("early ready");
  property p_bypass;
    !dll_disable_n |-> !dll_locked;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass lock");
  property p_stop;
    kidle == 4'hA |-> !device_ready;
  endproperty
  a_stop: assert property (p_stop) else $error("stop no reset");
  property p_dis_reset;
    $rose(dll_disable_n) |-> ##[2:6] !device_ready;
  endproperty
  a_dis_reset: assert property (p_dis_reset) else $error("toggle no reset");
  property p_burst;
    $fell(data_out_oe_n) |-> !data_out_oe_n [*7];
  endproperty
  a_burst: assert property (p_burst) else $error("short burst");
  property p_cause;
    $fell(data_out_oe_n) |-> rhist != 3'h0;
  endproperty
  a_cause: assert property (p_cause) else $error("data no read");
endmodule
bind burst2_sram_port burst2_sram_port_properties u_props (.clk, .rstn, .k_true,
  .read_sel_n, .dll_disable_n, .termination_select, .termination_select_float,
  .term_clk_on, .term_data_on, .term_strong, .data_out_oe_n, .device_ready, .dll_locked);

/* File: bench/ctrl_model.sv */
// controller-side model: true and complementary k clocks
// clocks stand still while run is low; pins move at clk falling edges
`timescale 1ns/1ps
module ctrl_model #(
  parameter int HALF = 4
) (
  // core clock and run control
  input wire logic clk,
  input wire logic run,
  // link clocks
  output wire logic k_true,
  output wire logic k_comp
);
  logic ph = 1'b0;
  int cnt = 0;
  assign k_true = ph;
  assign k_comp = ~ph;
  always @(negedge clk)
    if (run)
    begin
      cnt <= cnt == HALF - 1 ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        ph <= ~ph;
    end
endmodule

/* File: bench/tb.sv */
// bench for the burst-of-two sram port: termination, lock, traffic, clock stop
// commands change at clk falling edges, clear of the pin samplers
`timescale 1ns/1ps
module tb;
  logic clk, rstn, run, read_sel_n, write_sel_n, dll_disable_n, tsel, tflt;
  logic full, prt, pwt, pnop;
  logic [5:0] addr;
  logic [3:0] mask;
  logic [35:0] data_in;
  logic [35:0] mem [64];
  logic [35:0] sb [$];
  wire logic k_true, k_comp, term_clk_on, term_data_on, term_strong;
  wire logic data_out_oe_n, device_ready, dll_locked;
  wire logic [35:0] data_out;
  int n_errors, cmp_count, seed, krises, i;
  ctrl_model u_ctrl_model (.clk, .run, .k_true, .k_comp);
  burst2_sram_port u_burst2_sram_port (.clk, .rstn, .ce(1'b1), .k_true, .k_comp,
    .read_sel_n, .write_sel_n, .addr, .data_in, .byte_write_mask_n(mask), .dll_disable_n,
    .termination_select(tsel), .termination_select_float(tflt), .term_clk_on,
    .term_data_on, .term_strong, .data_out, .data_out_oe_n, .device_ready, .dll_locked,
    .write_ready());
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge k_true)
    krises++;
  task check(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task wait_ready;
    for (int n = 0; n < 20000 && device_ready !== 1'b1; n++)
      @(negedge clk);
    if (device_ready !== 1'b1)
    begin
      n_errors++;
      $display("[FAIL] %0t no ready", $time);
      tally_and_finish;
    end
    check(36'(krises > 2047 && krises < 2053), 36'h1);
  endtask
  task slot(input logic rd, input logic wr, input logic [5:0] ra, input logic [5:0] wa);
    logic [35:0] d1, d2;
    logic [3:0] m1, m2;
    logic rok, wok;
    d1 = 36'({$random(seed), $random(seed)});
    d2 = 36'({$random(seed), $random(seed)});
    m1 = full ? 4'h0 : 4'($random(seed));
    m2 = full ? 4'h0 : 4'($random(seed));
    rok = rd && !prt;
    wok = wr && !pwt && !(pnop && rd);
    prt = rok;
    pwt = wok;
    pnop = !rd && !wr;
    @(posedge k_comp);
    repeat (3) @(negedge clk);
    read_sel_n = !rd;
    write_sel_n = !wr;
    addr = ra;
    data_in = d1;
    mask = m1;
    @(posedge k_true);
    repeat (3) @(negedge clk);
    addr = wa;
    data_in = d2;
    mask = m2;
    if (rok)
    begin
      sb.push_back(mem[ra]);
      sb.push_back(mem[ra + 6'h01]);
    end
    for (int b = 0; b < 4; b++)
    begin
      if (wok && !m1[b])
        mem[wa][9*b+:9] = d1[9*b+:9];
      if (wok && !m2[b])
        mem[wa + 6'h01][9*b+:9] = d2[9*b+:9];
    end
  endtask
  // result of the previous k edge, looked at mid-half
  initial
    forever
    begin
      @(posedge k_true or posedge k_comp);
      repeat (2) @(negedge clk);
      if (data_out_oe_n === 1'b0)
        check(data_out, sb.size() > 0 ? sb.pop_front() : 36'hX);
    end
  initial
  begin
    seed = 33;
    n_errors = 0;
    cmp_count = 0;
    krises = 0;
    {rstn, run, read_sel_n, write_sel_n, dll_disable_n, tsel, tflt} = 7'b0011000;
    {full, prt, pwt, pnop} = 4'b1001;
    addr = 6'h00;
    data_in = 36'h0;
    mask = 4'hF;
    repeat (4) @(negedge clk);
    check(36'({data_out_oe_n, device_ready, term_clk_on}), 36'h4);
    rstn = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      {tsel, tflt} = 2'(i);
      repeat (6) @(negedge clk);
      check(36'({term_strong, term_clk_on, term_data_on}), 36'({i == 0, 2'b11}));
    end
    $display("termination done");
    run = 1'b1;
    wait_ready;
    check(36'(dll_locked), 36'h0);
    dll_disable_n = 1'b1;
    krises = 0;
    repeat (8) @(negedge clk);
    check(36'(device_ready), 36'h0);
    wait_ready;
    check(36'(dll_locked), 36'h1);
    $display("lock done");
    for (i = 0; i < 64; i += 2)
    begin
      slot(1'b0, 1'b1, 6'h00, 6'(i));
      slot(1'b0, 1'b0, 6'h00, 6'h00);
    end
    full = 1'b0;
    repeat (200)
      slot(1'($random(seed)), 1'($random(seed)), 6'($random(seed)) & 6'h1E,
        6'h20 | (6'($random(seed)) & 6'h1E));
    for (i = 28; i < 68; i++)
      slot(i > 31 && i < 64 && i % 2 == 0, 1'b0, 6'(i), 6'h00);
    check(36'(sb.size()), 36'h0);
    $display("traffic done");
    run = 1'b0;
    repeat (10) @(negedge clk);
    check(36'(device_ready), 36'h0);
    krises = 0;
    run = 1'b1;
    wait_ready;
    $display("clock stop done");
    tally_and_finish;
  end
endmodule

/* File: verilog/burst2_sram_pkg.sv */
// types shared by the burst-of-two sram port
// assumes nothing of its surroundings
package burst2_sram_pkg;

  typedef enum logic [1:0] {
    DLL_LOCKING = 2'b01,
    DLL_READY = 2'b10
  } dll_state_t;

  typedef enum logic [1:0] {
    TERM_OPTION_1 = 2'h1,
    TERM_OPTION_2 = 2'h2
  } term_option_t;

endpackage

/* File: verilog/burst2_sram_port.sv */
// burst-of-two ddr sram port: dll start-up, termination decode, read and write machines
// assumes link pins arrive asynchronously and are oversampled by clk
//
// Overview of operation
// - option 1: termination-select low gives strong, high gives weak on clocks, data, masks
// - option 1: floating termination-select reads as high, so weak termination
// - option 2: high enables weak on data and masks; low or floating disables
// - after stable clocks wait lock-wait interval, lock dll, then accept operations
// - dll-disable low skips locking; ready after lock-wait interval of stable clock
// - either input clock static over 30 ns resets dll; relock over interval
// - rising edge of dll-disable resets dll; relock over lock-wait interval
// - burst is two beats linear; second beat uses registered address plus one
// - read active on read select sampled low; write active on write select low
// - read and write machines accept commands only on true clock rising edges
// - read and write machines run independently and may overlap
// - read data beat one at comp edge t+2.5, beat two at true edge t+3.0
// - dll locks once 2048 stable clock cycles have passed after reset
// - same-type command on the edge right after an accepted one is ignored
// - both selects low after a no-operation cycle: read done, write discarded
`timescale 1ns/1ps
`include "burst2_sram_regs.svh"
module burst2_sram_port
  import burst2_sram_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int BYTES = 4,
  parameter int BYTE_W = 9,
  parameter int FIFO_DEPTH = `WR_FIFO_DEPTH,
  parameter term_option_t TERM_OPTION = TERM_OPTION_1
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // link clocks and commands
  input wire logic k_true,
  input wire logic k_comp,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [BYTES*BYTE_W-1:0] data_in,
  input wire logic [BYTES-1:0] byte_write_mask_n,
  input wire logic dll_disable_n,
  // termination control
  input wire logic termination_select,
  input wire logic termination_select_float,
  output logic term_clk_on,
  output logic term_data_on,
  output logic term_strong,
  // read data
  output logic [BYTES*BYTE_W-1:0] data_out,
  output logic data_out_oe_n,
  // status
  output logic device_ready,
  output logic dll_locked,
  output logic write_ready
);
  localparam int DW = BYTES * BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int FW = ADDR_W + 2 * (DW + BYTES);
  localparam int SW = 2 + ADDR_W + DW + BYTES + 5;
  localparam logic [3:0] STOP_LIMIT = 4'(`KSTOP_CYCLES);
  localparam logic [11:0] LOCK_LIMIT = 12'(`LOCK_WAIT_INTERVAL - 1);

  // two-flop synchronisers for every pin
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic kt;
  logic kc;
  logic kt_d;
  logic kc_d;
  logic rd_n;
  logic wr_n;
  logic [ADDR_W-1:0] a_s;
  logic [DW-1:0] d_s;
  logic [BYTES-1:0] m_s;
  logic doff_n;
  logic doff_n_d;
  logic tsel;
  logic tflt;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else if (ce)
    begin
      sync1 <= {k_true, k_comp, addr, data_in, byte_write_mask_n, read_sel_n, write_sel_n,
        dll_disable_n, termination_select, termination_select_float};
      sync2 <= sync1;
    end
  end

  assign {kt, kc, a_s, d_s, m_s, rd_n, wr_n, doff_n, tsel, tflt} = sync2;

  logic kt_rise;
  logic kc_rise;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      kt_d <= 1'b0;
      kc_d <= 1'b0;
      doff_n_d <= 1'b0;
    end
    else if (ce)
    begin
      kt_d <= kt;
      kc_d <= kc;
      doff_n_d <= doff_n;
    end
  end

  assign kt_rise = kt && !kt_d;
  assign kc_rise = kc && !kc_d;

  // termination decode
  logic tsel_high;

  assign tsel_high = tsel || tflt;
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      term_clk_on <= 1'b0;
      term_data_on <= 1'b0;
      term_strong <= 1'b0;
    end
    else if (ce)
    begin
      if (TERM_OPTION == TERM_OPTION_1)
      begin
        term_clk_on <= 1'b1;
        term_data_on <= 1'b1;
        term_strong <= !tsel_high;
      end
      else
      begin
        term_clk_on <= 1'b0;
        term_data_on <= tsel && !tflt;
        term_strong <= 1'b0;
      end
    end
  end

  // clock-stop detection
  logic [3:0] kt_idle;
  logic [3:0] kc_idle;
  logic kstop;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      kt_idle <= `STOP_CNT_RST;
      kc_idle <= `STOP_CNT_RST;
    end
    else if (ce)
    begin
      kt_idle <= (kt != kt_d) ? `STOP_CNT_RST : (kt_idle == STOP_LIMIT) ? kt_idle : kt_idle + 1'b1;
      kc_idle <= (kc != kc_d) ? `STOP_CNT_RST : (kc_idle == STOP_LIMIT) ? kc_idle : kc_idle + 1'b1;
    end
  end

  assign kstop = (kt_idle == STOP_LIMIT) || (kc_idle == STOP_LIMIT);

  // dll start-up and relock
  dll_state_t dll_state;
  dll_state_t next_dll_state;
  logic [11:0] lock_cnt;
  logic dll_reset;

  assign dll_reset = kstop || (doff_n && !doff_n_d);

  always_comb
  begin
    next_dll_state = dll_state;
    case (dll_state)
      DLL_LOCKING:
        if (!dll_reset && kt_rise && lock_cnt == LOCK_LIMIT)
          next_dll_state = DLL_READY;
      DLL_READY:
        if (dll_reset)
          next_dll_state = DLL_LOCKING;
      default:
        next_dll_state = DLL_LOCKING;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dll_state <= DLL_LOCKING;
      lock_cnt <= `LOCK_CNT_RST;
    end
    else if (ce)
    begin
      dll_state <= next_dll_state;
      if (dll_reset || dll_state == DLL_READY)
        lock_cnt <= `LOCK_CNT_RST;
      else if (kt_rise)
        lock_cnt <= lock_cnt + 1'b1;
    end
  end

  assign device_ready = (dll_state == DLL_READY);
  assign dll_locked = device_ready && doff_n;

  // command acceptance on true clock edges
  logic rd_last;
  logic wr_last;
  logic nop_last;
  logic rd_go;
  logic wr_go;

  assign rd_go = kt_rise && device_ready && !rd_n && !rd_last;
  assign wr_go = kt_rise && device_ready && !wr_n && !wr_last
    && !(nop_last && !rd_n) && write_ready;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_last <= 1'b0;
      wr_last <= 1'b0;
      nop_last <= 1'b0;
    end
    else if (ce && kt_rise)
    begin
      rd_last <= rd_go;
      wr_last <= wr_go;
      nop_last <= rd_n && wr_n;
    end
  end

  // storage
  logic [DW-1:0] mem [DEPTH];
  logic fifo_out_valid;
  logic [FW-1:0] fifo_out;
  logic drain;
  logic [ADDR_W-1:0] wa;
  logic [DW-1:0] wd0;
  logic [DW-1:0] wd1;
  logic [BYTES-1:0] wm0;
  logic [BYTES-1:0] wm1;

  assign {wa, wd0, wm0, wd1, wm1} = fifo_out;
  assign drain = fifo_out_valid && !rd_go; // array port stalls during a read fetch

  always_ff @(posedge clk)
  begin
    if (ce && drain)
    begin
      for (int b = 0; b < BYTES; b++)
      begin
        if (!wm0[b])
          mem[wa][b*BYTE_W +: BYTE_W] <= wd0[b*BYTE_W +: BYTE_W];
        if (!wm1[b])
          mem[ADDR_W'(wa + 1'b1)][b*BYTE_W +: BYTE_W] <= wd1[b*BYTE_W +: BYTE_W];
      end
    end
  end

  // write machine: beat one at true edge, address and beat two at comp edge
  logic wr_half;
  logic [DW-1:0] wr_d0;
  logic [BYTES-1:0] wr_m0;
  logic push;
  logic [FW-1:0] push_word;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_half <= 1'b0;
      wr_d0 <= '0;
      wr_m0 <= '1;
      push <= 1'b0;
      push_word <= '0;
    end
    else if (ce)
    begin
      push <= 1'b0;
      if (wr_go)
      begin
        wr_half <= 1'b1;
        wr_d0 <= d_s;
        wr_m0 <= m_s;
      end
      else if (wr_half && kc_rise)
      begin
        wr_half <= 1'b0;
        push <= 1'b1;
        push_word <= {a_s, wr_d0, wr_m0, d_s, m_s};
      end
    end
  end

  write_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(push),
    .in_ready(write_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(fifo_out)
  );

  // read machine: two-cycle pipeline counted in true clock edges
  logic [1:0] rd_stage;
  logic [DW-1:0] rd0_s0;
  logic [DW-1:0] rd1_s0;
  logic [DW-1:0] rd0_s1;
  logic [DW-1:0] rd1_s1;
  logic rd_due;
  logic beat2_pend;
  logic [DW-1:0] beat2;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_stage <= 2'h0;
      rd0_s0 <= '0;
      rd1_s0 <= '0;
      rd0_s1 <= '0;
      rd1_s1 <= '0;
    end
    else if (ce && kt_rise)
    begin
      rd_stage <= {rd_stage[0], rd_go};
      rd0_s1 <= rd0_s0;
      rd1_s1 <= rd1_s0;
      if (rd_go)
      begin
        rd0_s0 <= mem[a_s];
        rd1_s0 <= mem[ADDR_W'(a_s + 1'b1)];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_due <= 1'b0;
      beat2_pend <= 1'b0;
      beat2 <= '0;
      data_out <= '0;
      data_out_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (kt_rise)
      begin
        rd_due <= rd_stage[1];
        if (beat2_pend)
        begin
          data_out <= beat2;
          beat2_pend <= 1'b0;
        end
      end
      if (kt_rise && rd_stage[1])
        beat2 <= rd1_s1;
      if (kc_rise)
      begin
        rd_due <= 1'b0;
        if (rd_due)
        begin
          data_out <= rd0_s1;
          data_out_oe_n <= 1'b0;
          beat2_pend <= 1'b1;
        end
        else
          data_out_oe_n <= 1'b1;
      end
    end
  end
endmodule

/* File: verilog/burst2_sram_regs.svh */
// timing counts and reset values for the burst-of-two sram port
// assumes a 125 MHz core clock sampling the link pins
`ifndef BURST2_SRAM_REGS_SVH
`define BURST2_SRAM_REGS_SVH

`define CORE_CLK_PERIOD_NS 8
`define KSTOP_MIN_NS 30
`define KSTOP_CYCLES ((`KSTOP_MIN_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define LOCK_WAIT_INTERVAL 2048
`define TERM_OPTION_DEFAULT 1
`define BURST_LEN 2
`define WR_FIFO_DEPTH 8
`define STOP_CNT_RST 4'h0
`define LOCK_CNT_RST 12'h000

`endif

/* File: verilog/write_fifo.sv */
// write-buffer fifo, flip-flop storage addressed by index
// assumes one clock, synchronous active-low reset and a clock enable
`timescale 1ns/1ps
module write_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_ptr] <= in_data;
  end
endmodule
